// ### core/egpic_irq_fifo.sv
// Queue of canceller channel numbers awaiting host service.
// Assumes one push and one pop at most per cycle.
`timescale 1ns/1ps
module egpic_irq_fifo
  import egpic_pkg::*;
#(
  parameter int WIDTH = CH_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] cnt;
  } egpic_fifo_t;
  egpic_fifo_t s_q, s_d;
  logic do_push, do_pop;

  always_comb begin
    s_d = s_q;
    do_pop = pop && (s_q.cnt != '0);
    // Overflow drops the newest event rather than corrupting the queue
    do_push = push && (s_q.cnt != (PW+1)'(DEPTH) || do_pop);
    if (do_push) begin
      s_d.mem[s_q.wr] = push_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (do_pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign head = s_q.mem[s_q.rd];
  assign empty = (s_q.cnt == '0);
  assign full = (s_q.cnt == (PW+1)'(DEPTH));
endmodule : egpic_irq_fifo

// ### core/egpic_pass_delay.sv
// Two-frame sample delay line used for power-down pass-through.
// Assumes samples are presented and taken on the frame strobe.
`timescale 1ns/1ps
module egpic_pass_delay
  import egpic_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FRAME_DELAY
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic frame_stb,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // Stage 0 captures; the sample leaves DEPTH strobes later
  typedef struct packed {
    logic [DEPTH:0][WIDTH-1:0] stage;
  } egpic_dly_t;
  egpic_dly_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (frame_stb) begin
      s_d.stage[0] = din;
      for (int i = 1; i <= DEPTH; i++) begin
        s_d.stage[i] = s_q.stage[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stage[DEPTH];
endmodule : egpic_pass_delay

// ### core/egpic_pkg.sv
// Constants shared by the echo group power and interrupt control block.
// Assumes a 10 MHz ref_clk and a frame strobe from the PCM framing logic.
package egpic_pkg;
  localparam int NUM_GROUPS = 2;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int ADDR_W = 11;
  // Per-canceller block: 32 bytes each, canceller index in addr[6:5]
  localparam logic [10:0] CH_REGION_MASK = 11'h780;
  localparam logic [10:0] CH_REGION_BASE = 11'h000;
  localparam logic [4:0] OFF_CTRL_ONE = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h02;
  localparam int CH_SEL_LSB = 5;
  localparam logic [10:0] MAIN_CTRL_BASE = 11'h400;
  localparam logic [10:0] IRQ_FIFO_ADDR = 11'h410;
  // Main control bits
  localparam int BIT_GROUP_POWER_UP = 0;
  localparam int BIT_A_TONE_IRQ_MASK = 3;
  localparam int BIT_B_TONE_IRQ_MASK = 4;
  localparam int BIT_GLOBAL_IRQ_MASK = 5;
  // First control register bits, then the status tone-disable bit
  localparam int BIT_PAIR_CASCADE = 0;
  localparam int BIT_ADAPT_FREEZE = 2;
  localparam int BIT_BYPASS = 3;
  localparam int BIT_PAD = 4;
  localparam int BIT_BACK_TO_BACK = 5;
  localparam int BIT_NOISE_OFF = 6;
  localparam int BIT_INIT = 7;
  localparam int BIT_TONE_DISABLE = 0;
  localparam logic [7:0] CTRL_ONE_RESET_A = 8'h00;
  localparam logic [7:0] CTRL_ONE_RESET_B = 8'h02;
  localparam logic [7:0] MAIN_RESET = 8'h00;
  localparam logic [7:0] QUIET_CODE = 8'hFF;
  localparam logic [7:0] EMPTY_FIFO_READ = 8'h00;
  localparam int FRAME_DELAY = 2;
  localparam int INIT_FRAMES = 2;
  localparam logic [1:0] INIT_FRAMES_W = 2'h2;
  localparam int FIFO_DEPTH = 8;
endpackage : egpic_pkg

// ### core/egpic_top.sv
// Group power, call init and tone-disable interrupt control.
// Assumes host port strobes are synchronous to ref_clk, one cycle each.
//
// How it works
// - Writing zero to a group power-up bit powers that group down.
// - A powered-down group passes its PCM unchanged, two frames late.
// - Each canceller raises an event on tone-disable onset and release.
// - Every pending event queues its channel number for host reads; when the queue is full, the newest is dropped.
// - The pin goes high after each FIFO read, low again while pending.
// - Status holds a live tone-disable flag per canceller.
// - Global mask bit 5 of main control 0 blocks all interrupts.
// - Bits 4 and 3 of a group main control mask cancellers B and A.
// - Adaptation freeze holds coefficients while still cancelling.
// - Cascade bit 0 of canceller A makes the pair one long canceller.
// - Power-up rising edge restores defaults and clears within 2 frames.
// - In cascade or back-to-back, canceller B's channel sends quiet code.
`timescale 1ns/1ps
module egpic_top
  import egpic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic frame_stb,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic irq_n,
  input wire logic [NUM_CH-1:0] tone_detect,
  input wire logic [NUM_CH-1:0][7:0] rin_in,
  input wire logic [NUM_CH-1:0][7:0] sin_in,
  input wire logic [NUM_CH-1:0][7:0] rin_proc,
  input wire logic [NUM_CH-1:0][7:0] sout_proc,
  output logic [NUM_CH-1:0][7:0] rout,
  output logic [NUM_CH-1:0][7:0] sout,
  output logic [NUM_CH-1:0] adapt_run,
  output logic [NUM_CH-1:0] coef_clear,
  output logic [NUM_CH-1:0] noise_inject_en,
  output logic [NUM_CH-1:0] pad_12db,
  output logic [NUM_CH-1:0] bypass_en,
  output logic [NUM_GROUPS-1:0] group_cascade,
  output logic [NUM_GROUPS-1:0] group_active
);
  typedef struct packed {
    logic [NUM_GROUPS-1:0][7:0] main_ctrl;
    logic [NUM_CH-1:0][7:0] ctrl_one;
    logic [NUM_CH-1:0] td_seen;
    logic [NUM_GROUPS-1:0][1:0] init_cnt;
    logic [7:0] rdata;
    logic irq_n;
    logic irq_gap;
    logic [NUM_CH-1:0][7:0] rout;
    logic [NUM_CH-1:0][7:0] sout;
    logic [NUM_CH-1:0] adapt_run;
    logic [NUM_CH-1:0] coef_clear;
    logic [NUM_CH-1:0] noise_en;
    logic [NUM_CH-1:0] pad;
    logic [NUM_CH-1:0] bypass;
    logic [NUM_GROUPS-1:0] cascade;
    logic [NUM_GROUPS-1:0] active;
  } egpic_state_t;
  egpic_state_t s_q, s_d;

  function automatic logic [7:0] ctrl_default(input int ch);
    return (ch % 2 == 0) ? CTRL_ONE_RESET_A : CTRL_ONE_RESET_B;
  endfunction : ctrl_default

  function automatic logic is_ch_reg(input logic [ADDR_W-1:0] a,
                                     input logic [4:0] off);
    return ((a & CH_REGION_MASK) == CH_REGION_BASE) && (a[4:0] == off);
  endfunction : is_ch_reg

  logic [NUM_CH-1:0][7:0] dly_r, dly_s;
  logic fifo_push, fifo_pop, fifo_empty;
  logic [CH_W-1:0] fifo_push_ch, fifo_head;
  logic [NUM_CH-1:0] event_raw;
  logic [CH_W-1:0] ch_idx;
  logic main_hit, fifo_hit;
  logic [2:0] main_idx;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_dly
    egpic_pass_delay #(.WIDTH(8), .DEPTH(FRAME_DELAY)) u_dr (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .frame_stb(frame_stb),
      .din(rin_in[c]),
      .dout(dly_r[c])
    );
    egpic_pass_delay #(.WIDTH(8), .DEPTH(FRAME_DELAY)) u_ds (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .frame_stb(frame_stb),
      .din(sin_in[c]),
      .dout(dly_s[c])
    );
  end

  egpic_irq_fifo #(.WIDTH(CH_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .push(fifo_push),
    .push_data(fifo_push_ch),
    .pop(fifo_pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .full()
  );

  assign ch_idx = host_addr[CH_SEL_LSB +: CH_W];
  assign main_hit = (host_addr & ~11'h007) == MAIN_CTRL_BASE;
  assign main_idx = host_addr[2:0];
  assign fifo_hit = host_addr == IRQ_FIFO_ADDR;
  assign fifo_pop = host_rd && fifo_hit;

  // Edges on the live tone flag give onset and release events
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      event_raw[c] = (tone_detect[c] != s_q.td_seen[c])
        && s_q.active[c/2]
        && !s_q.main_ctrl[c/2][(c % 2 == 0) ? BIT_A_TONE_IRQ_MASK
                                            : BIT_B_TONE_IRQ_MASK]
        && !s_q.main_ctrl[0][BIT_GLOBAL_IRQ_MASK];
    end
    // One push per cycle; lowest channel first, the others follow one per cycle
    fifo_push = 1'b0;
    fifo_push_ch = '0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (event_raw[c]) begin
        fifo_push = 1'b1;
        fifo_push_ch = CH_W'(c);
      end
    end
  end

  always_comb begin
    s_d = s_q;
    for (int c = 0; c < NUM_CH; c++) begin
      s_d.coef_clear[c] = 1'b0;
      // Masked events are consumed so they never surface later
      if (tone_detect[c] != s_q.td_seen[c]) begin
        if (!event_raw[c] || (fifo_push_ch == CH_W'(c))) begin
          s_d.td_seen[c] = tone_detect[c];
        end
      end
    end
    // Host writes
    if (host_wr && main_hit && main_idx < 3'(NUM_GROUPS)) begin
      s_d.main_ctrl[main_idx] = host_wdata;
    end
    if (host_wr && is_ch_reg(host_addr, OFF_CTRL_ONE)) begin
      s_d.ctrl_one[ch_idx] = host_wdata;
      if (host_wdata[BIT_INIT]) begin
        s_d.ctrl_one[ch_idx] = ctrl_default(int'(ch_idx));
        s_d.coef_clear[ch_idx] = 1'b1;
      end
    end
    // Group power sequencing
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (!s_q.main_ctrl[g][BIT_GROUP_POWER_UP]) begin
        s_d.active[g] = 1'b0;
        s_d.init_cnt[g] = '0;
      end else if (!s_q.active[g] && s_q.init_cnt[g] == '0) begin
        s_d.init_cnt[g] = INIT_FRAMES_W;
        s_d.ctrl_one[2*g] = ctrl_default(2*g);
        s_d.ctrl_one[2*g+1] = ctrl_default(2*g+1);
        s_d.coef_clear[2*g] = 1'b1;
        s_d.coef_clear[2*g+1] = 1'b1;
      end else if (s_q.init_cnt[g] != '0) begin
        s_d.coef_clear[2*g] = 1'b1;
        s_d.coef_clear[2*g+1] = 1'b1;
        if (frame_stb) begin
          s_d.init_cnt[g] = s_q.init_cnt[g] - 2'h1;
          if (s_q.init_cnt[g] == 2'h1) begin
            s_d.active[g] = 1'b1;
          end
        end
      end
      s_d.cascade[g] = s_q.ctrl_one[2*g][BIT_PAIR_CASCADE];
    end
    // Per-canceller controls and PCM routing
    for (int c = 0; c < NUM_CH; c++) begin
      s_d.adapt_run[c] = s_q.active[c/2]
        && !s_q.ctrl_one[c][BIT_ADAPT_FREEZE]
        && !s_q.ctrl_one[c][BIT_BYPASS];
      s_d.bypass[c] = s_q.ctrl_one[c][BIT_BYPASS];
      s_d.noise_en[c] = !s_q.ctrl_one[c][BIT_NOISE_OFF];
      s_d.pad[c] = s_q.ctrl_one[c][BIT_PAD];
      if (!s_q.active[c/2]) begin
        s_d.rout[c] = dly_r[c];
        s_d.sout[c] = dly_s[c];
      end else if ((c % 2 == 1) &&
                   (s_q.ctrl_one[c-1][BIT_PAIR_CASCADE] ||
                    s_q.ctrl_one[c-1][BIT_BACK_TO_BACK])) begin
        s_d.rout[c] = QUIET_CODE;
        s_d.sout[c] = QUIET_CODE;
      end else begin
        s_d.rout[c] = rin_proc[c];
        s_d.sout[c] = sout_proc[c];
      end
    end
    // Host read data, registered one cycle after the strobe
    if (host_rd) begin
      s_d.rdata = 8'h00;
      if (fifo_hit) begin
        s_d.rdata = fifo_empty ? EMPTY_FIFO_READ
                               : {6'h00, fifo_head};
      end else if (main_hit && main_idx < 3'(NUM_GROUPS)) begin
        s_d.rdata = s_q.main_ctrl[main_idx];
      end else if (is_ch_reg(host_addr, OFF_CTRL_ONE)) begin
        s_d.rdata = s_q.ctrl_one[ch_idx];
      end else if (is_ch_reg(host_addr, OFF_STATUS)) begin
        s_d.rdata = 8'h00;
        s_d.rdata[BIT_TONE_DISABLE] = tone_detect[ch_idx];
      end
    end
    // Pin rises for two cycles after each FIFO read, then falls if pending
    s_d.irq_gap = fifo_pop;
    s_d.irq_n = fifo_pop || s_q.irq_gap || fifo_empty
      || s_q.main_ctrl[0][BIT_GLOBAL_IRQ_MASK];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.irq_n <= 1'b1;
      s_q.ctrl_one[1] <= CTRL_ONE_RESET_B;
      s_q.ctrl_one[3] <= CTRL_ONE_RESET_B;
      s_q.noise_en <= '1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign host_rdata = s_q.rdata;
  assign irq_n = s_q.irq_n;
  assign rout = s_q.rout;
  assign sout = s_q.sout;
  assign adapt_run = s_q.adapt_run;
  assign coef_clear = s_q.coef_clear;
  assign noise_inject_en = s_q.noise_en;
  assign pad_12db = s_q.pad;
  assign bypass_en = s_q.bypass;
  assign group_cascade = s_q.cascade;
  assign group_active = s_q.active;
endmodule : egpic_top

// ### verif/egpic_host_model.sv
// Host processor model on the parallel register port.
// Assumes one-cycle strobes and read data one cycle after the read edge.
`timescale 1ns/1ps
module egpic_host_model
  import egpic_pkg::*;
(
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] host_addr = '0,
  output logic [7:0] host_wdata = 8'h00,
  output logic host_wr = 1'b0,
  output logic host_rd = 1'b0,
  input wire logic [7:0] host_rdata
);
  // Released data flips so a stale byte never passes for valid
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #5;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge ref_clk);
    #5;
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask : write_reg
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #5;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge ref_clk);
    #5;
    host_rd = 1'b0;
    d = host_rdata;
  endtask : read_reg
endmodule : egpic_host_model

// ### verif/egpic_monitor.sv
// Port assertions for egpic_top.
// Assumes bind into egpic_top; clk_en is held high by the bench.
`timescale 1ns/1ps
module egpic_monitor
  import egpic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_rdata,
  input wire logic irq_n,
  input wire logic [NUM_CH-1:0] tone_detect,
  input wire logic [NUM_CH-1:0] noise_inject_en,
  input wire logic [NUM_GROUPS-1:0] group_cascade,
  input wire logic [NUM_GROUPS-1:0] group_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] main0_q;
  logic fifo_rd;
  logic ch0_wr;
  assign fifo_rd = clk_en && host_rd && host_addr == IRQ_FIFO_ADDR;
  assign ch0_wr = clk_en && host_wr && host_addr == 11'h000 && group_active[0];
  // Shadow of main control 0; only its masks are judged
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      main0_q <= MAIN_RESET;
    end else if (clk_en && host_wr && host_addr == MAIN_CTRL_BASE) begin
      main0_q <= host_wdata;
    end
  end
  chk_read_lifts_irq: assert property (fifo_rd |=> irq_n ##1 irq_n)
    else $error("irq low right after queue read");
  chk_irq_rise_cause: assert property ($rose(irq_n) |->
    $past(fifo_rd) || main0_q[BIT_GLOBAL_IRQ_MASK])
    else $error("irq released without read or mask");
  chk_global_mask: assert property (main0_q[5] |=> irq_n)
    else $error("irq low under global mask");
  chk_tone_event: assert property ($changed(tone_detect[0])
    && group_active[0] && !main0_q[5] && !main0_q[3] && !host_rd
    |-> ##[1:6] !irq_n)
    else $error("tone change gave no irq");
  chk_power_down: assert property (clk_en && host_wr
    && host_addr == MAIN_CTRL_BASE && !host_wdata[0]
    |-> ##[1:2] !group_active[0])
    else $error("group stayed active");
  chk_status_flag: assert property (clk_en && host_rd
    && host_addr == 11'h002 |=> host_rdata[0] == $past(tone_detect[0]))
    else $error("status flag wrong");
  chk_cascade_set: assert property (ch0_wr && host_wdata[0]
    && !host_wdata[7] |-> ##[1:2] group_cascade[0])
    else $error("cascade not set");
  chk_noise_off: assert property (ch0_wr && host_wdata[6]
    && !host_wdata[7] |-> ##[1:2] !noise_inject_en[0])
    else $error("noise still on");
  chk_init_preset: assert property (ch0_wr && host_wdata[7]
    |-> ##[1:3] !group_cascade[0])
    else $error("init left cascade");
endmodule : egpic_monitor

// ### verif/tb.sv
// Self-checking bench for egpic_top driven through the host model.
// Assumes package constants give the address map and bit layout.
`timescale 1ns/1ps
module tb
  import egpic_pkg::*;
();
  localparam int FRAME = 16;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic frame_stb = 1'b0;
  logic [ADDR_W-1:0] host_addr;
  logic [7:0] host_wdata, host_rdata;
  logic host_wr, host_rd, irq_n;
  logic [NUM_CH-1:0] tone_detect = '0;
  logic [NUM_CH-1:0] adapt_run, coef_clear, noise_inject_en, pad_12db;
  logic [NUM_CH-1:0] bypass_en;
  logic [NUM_CH-1:0][7:0] rin_in = '0;
  logic [NUM_CH-1:0][7:0] sin_in = '0;
  logic [NUM_CH-1:0][7:0] rout, sout;
  logic [NUM_GROUPS-1:0] group_cascade, group_active;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int fcnt = 0;
  egpic_host_model host (.ref_clk, .host_addr, .host_wdata, .host_wr,
    .host_rd, .host_rdata);
  egpic_top uut (.ref_clk, .rst_b, .clk_en(1'b1), .frame_stb, .host_addr,
    .host_wdata, .host_wr, .host_rd, .host_rdata, .irq_n, .tone_detect,
    .rin_in, .sin_in, .rin_proc(~rin_in), .sout_proc(~sin_in), .rout, .sout,
    .adapt_run, .coef_clear, .noise_inject_en, .pad_12db, .bypass_en,
    .group_cascade, .group_active);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // Run needs about 330 cycles; the ceiling leaves ample slack
  always @(posedge ref_clk) begin
    #5;
    fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
    frame_stb <= (fcnt == FRAME - 1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] got, exp, input string msg);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : cyc
  task automatic frames(input int n);
    repeat (n) @(posedge ref_clk iff fcnt == FRAME - 1);
    #5;
  endtask : frames
  task automatic rdchk(input logic [10:0] a, input logic [7:0] e, string m);
    logic [7:0] d;
    host.read_reg(a, d);
    check(d, e, m);
  endtask : rdchk
  task automatic test_power_up();
    rdchk(11'h020, 8'h02, "b reset");
    rdchk(IRQ_FIFO_ADDR, 8'h00, "empty queue");
    host.write_reg(11'h3E0, 8'hFF);
    rdchk(11'h3E0, 8'h00, "unmapped");
    host.write_reg(11'h000, 8'h44);
    host.write_reg(MAIN_CTRL_BASE, 8'h01);
    host.write_reg(MAIN_CTRL_BASE + 11'h1, 8'h01);
    frames(2);
    cyc(3);
    check(8'(group_active), 8'h03, "groups up");
    rdchk(11'h000, 8'h00, "a preset");
  endtask : test_power_up
  task automatic test_ctrl_bits();
    host.write_reg(11'h000, 8'h44);
    cyc(2);
    check(8'({noise_inject_en[0], adapt_run[0]}), 8'h00, "frozen");
    rdchk(11'h000, 8'h44, "a rw");
    host.write_reg(11'h000, 8'h18);
    cyc(2);
    check(8'({pad_12db[0], bypass_en[0]}), 8'h03, "pad bypass");
    frames(2);
    host.write_reg(11'h000, 8'h00);
    cyc(2);
    check(8'(adapt_run[0]), 8'h01, "adapting");
    host.write_reg(11'h020, 8'h86);
    check(8'(coef_clear[1]), 8'h01, "b coef clear");
    rdchk(11'h020, 8'h02, "b init");
  endtask : test_ctrl_bits
  task automatic test_tone_irq();
    host.write_reg(11'h000, 8'h80);
    tone_detect = 4'b0001;
    cyc(6);
    check(8'(irq_n), 8'h00, "onset irq");
    rdchk(IRQ_FIFO_ADDR, 8'h00, "source 0");
    rdchk(11'h002, 8'h01, "flag a");
    tone_detect = 4'b0010;
    cyc(6);
    rdchk(IRQ_FIFO_ADDR, 8'h00, "release 0");
    check(8'(irq_n), 8'h01, "lifted");
    cyc(2);
    check(8'(irq_n), 8'h00, "pending");
    rdchk(IRQ_FIFO_ADDR, 8'h01, "source 1");
    rdchk(11'h022, 8'h01, "flag b");
    cyc(4);
    check(8'(irq_n), 8'h01, "drained");
  endtask : test_tone_irq
  task automatic test_masks();
    logic [7:0] d;
    host.write_reg(MAIN_CTRL_BASE, 8'h09);
    host.write_reg(MAIN_CTRL_BASE + 11'h1, 8'h11);
    tone_detect = 4'b1011;
    cyc(6);
    check(8'(irq_n), 8'h01, "masked");
    tone_detect = 4'b1111;
    cyc(6);
    rdchk(IRQ_FIFO_ADDR, 8'h02, "source 2");
    cyc(4);
    check(8'(irq_n), 8'h01, "nothing masked queued");
    host.write_reg(MAIN_CTRL_BASE, 8'h21);
    tone_detect = 4'b1110;
    cyc(6);
    check(8'(irq_n), 8'h01, "global mask");
    host.write_reg(MAIN_CTRL_BASE, 8'h01);
    cyc(4);
    host.read_reg(IRQ_FIFO_ADDR, d);
  endtask : test_masks
  task automatic test_quiet();
    host.write_reg(11'h000, 8'h01);
    host.write_reg(11'h040, 8'h20);
    frames(3);
    cyc(2);
    check(8'(group_cascade), 8'h01, "cascade");
    check(rout[1], QUIET_CODE, "b quiet");
    check(sout[1], QUIET_CODE, "b quiet send");
    check(rout[3], QUIET_CODE, "b2b quiet");
    host.write_reg(11'h000, 8'h00);
  endtask : test_quiet
  task automatic test_pass();
    host.write_reg(MAIN_CTRL_BASE, 8'h00);
    cyc(2);
    check(8'(group_active[0]), 8'h00, "group 0 down");
    for (int k = 0; k < 6; k++) begin
      frames(1);
      rin_in[0] = 8'h30 + 8'(k);
      sin_in[1] = 8'hC0 + 8'(k);
      cyc(FRAME / 2);
      if (k >= 2) begin
        check(rout[0], 8'h30 + 8'(k - 2), "rin pass");
        check(sout[1], 8'hC0 + 8'(k - 2), "sin pass");
      end
    end
  endtask : test_pass
  initial begin
    repeat (20) @(posedge ref_clk);
    #5;
    rst_b = 1'b1;
    test_power_up();
    test_ctrl_bits();
    test_tone_irq();
    test_masks();
    test_quiet();
    test_pass();
    stop_test();
  end
endmodule : tb
bind egpic_top egpic_monitor mon (.ref_clk, .rst_b, .clk_en, .host_addr,
  .host_wdata, .host_wr, .host_rd, .host_rdata, .irq_n, .tone_detect,
  .noise_inject_en, .group_cascade, .group_active);
